// file: tsf_afe_model.sv
// tsf_afe_model: converter front end and neighbour link as the block sees them
// assumes the block's aclk; behavioural only, not for synthesis
`timescale 1ns/10ps
module tsf_afe_model (
    // clock
    input wire logic aclk,
    // from the block and the bench
    input wire logic [3:0] adc_channel,
    input wire logic adc_running,
    input wire logic link_en,
    // to the block
    output logic [11:0] adc_data,
    output logic link_activity
);
    logic [3:0] link_cnt;

    // conversion value follows the channel; idle bus flips so stale data never looks valid
    initial adc_data = 12'h000;
    always @(posedge aclk) begin
        if (adc_running) begin
            adc_data <= 12'h5A0 | {8'h00, adc_channel};
        end else begin
            adc_data <= ~adc_data;
        end
    end

    // link edges
    // the neighbour toggles every 16 cycles and stands still once disconnected
    initial link_cnt = 4'h0;
    initial link_activity = 1'b0;
    always @(posedge aclk) begin
        link_cnt <= link_cnt + 4'h1;
        if (link_en && link_cnt == 4'hF) begin
            link_activity <= ~link_activity;
        end
    end
endmodule

// file: tsf_pkg.sv
// tsf_pkg: constants and carrier types for the thermal shutdown and fault control block
// assumes a 10 MHz aclk and a 32-bit axi4-lite register bus
package tsf_pkg;
    // ***************************************************
    // timing
    // ***************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int STANDBY_TIMEOUT_MS = 2000;
    localparam int STANDBY_TIMEOUT_CYC = STANDBY_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
    localparam int CELL_CONV_US = 500;
    localparam int CELL_CONV_CYC = CELL_CONV_US * 1000 / CLK_PERIOD_NS;
    localparam int NUM_CELLS = 12;
    localparam logic [3:0] LAST_CELL_10 = 4'h9;
    localparam logic [3:0] LAST_CELL_12 = 4'hB;
    // ***************************************************
    // register map (byte addresses)
    // ***************************************************
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] TEMP_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] RES_OFS = 8'h40;
    localparam logic [7:0] RES_END_OFS = 8'h6C;
    // ***************************************************
    // field positions and reset values
    // ***************************************************
    localparam int CFG_DIS_LSB = 0;
    localparam int CFG_TEN_BIT = 12;
    localparam int CFG_ADC_BIT = 13;
    localparam int CMD_STACK_BIT = 0;
    localparam int CMD_CELL_BIT = 1;
    localparam int CMD_IDX_LSB = 4;
    localparam int TEMP_FLAG_BIT = 0;
    localparam int TEMP_ARMED_BIT = 1;
    localparam int TEMP_STBY_BIT = 2;
    localparam int IRQ_OT_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_LINK_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // configuration carrier, all zero by default
    typedef struct packed {
        logic adc_en;
        logic ten_cell_select;
        logic [11:0] discharge;
    } tsf_cfg_t;
    localparam tsf_cfg_t CFG_DEFAULT = '0;
endpackage

// file: tsf_top.sv
// tsf_top: over-temperature shutdown, stack conversion sequencer and link watchdog
// assumes an axi4-lite master on aclk; pins come from other domains and are synchronised
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module tsf_top #(
    parameter int TIMEOUT_CYC = tsf_pkg::STANDBY_TIMEOUT_CYC,
    parameter int CONV_CYC = tsf_pkg::CELL_CONV_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins from other domains
    input wire logic over_temp,
    input wire logic cm_io_active,
    input wire logic link_activity,
    input wire logic poll_from_above,
    input wire logic [11:0] cell_unused,
    // adc result, same clock
    input wire logic [11:0] adc_data,
    // outputs
    output logic [11:0] discharge_on,
    output logic [3:0] adc_channel,
    output logic adc_running,
    output logic poll_out,
    output logic standby,
    output logic irq
);
    initial begin
        if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << 25) || CONV_CYC < 2 || CONV_CYC >= (1 << 16))
            $error("tsf_top: count parameter out of range");
    end

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    logic [15:0] sy1_r, sy2_r, sy3_r, pin_r;
    // three stages; a level is taken only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sy1_r <= '0;
            sy2_r <= '0;
            sy3_r <= '0;
            pin_r <= '0;
        end else begin
            sy1_r <= {cell_unused, poll_from_above, link_activity, cm_io_active, over_temp};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            for (int i = 0; i < 16; i++) begin
                if (sy2_r[i] == sy3_r[i])
                    pin_r[i] <= sy3_r[i];
            end
        end
    end
    logic ot_s, cmio_s, link_s, poll_s;
    logic [11:0] unused_s;
    assign {unused_s, poll_s, link_s, cmio_s, ot_s} = pin_r;

    // ***************************************************
    // registers and protection
    // ***************************************************
    tsf_pkg::tsf_cfg_t cfg_r;
    logic flag_r, link_prev_r, ot_prev_r;
    logic [24:0] wd_r;
    logic [2:0] irq_stat_r, irq_mask_r;
    logic wr_go, rd_go, cmd_stack, cmd_cell, conv_done_ev;
    logic [7:0] wa_r, ra_r;
    logic [3:0] cmd_idx;
    logic armed, ot_event, link_ev;

    assign armed = !standby || cmio_s;
    assign ot_event = ot_s && !ot_prev_r && armed;
    assign link_ev = link_s != link_prev_r;

    function automatic logic [3:0] last_cell(input logic ten);
        last_cell = ten ? tsf_pkg::LAST_CELL_10 : tsf_pkg::LAST_CELL_12;
    endfunction

    // watchdog: any edge on the link restarts it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_prev_r <= 1'b0;
            ot_prev_r <= 1'b0;
            wd_r <= '0;
            standby <= 1'b0;
        end else begin
            link_prev_r <= link_s;
            ot_prev_r <= ot_s;
            if (link_ev) begin
                wd_r <= '0;
                standby <= 1'b0;
            end else if (wd_r == 25'(TIMEOUT_CYC - 1)) begin
                standby <= 1'b1;
            end else begin
                wd_r <= wd_r + 25'h000_0001;
            end
        end
    end

    // configuration; shutdown wins over a software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= tsf_pkg::CFG_DEFAULT;
        end else if (ot_event) begin
            cfg_r <= tsf_pkg::CFG_DEFAULT;
        end else if (wr_go && wa_r == tsf_pkg::CFG_OFS) begin
            cfg_r <= tsf_pkg::tsf_cfg_t'(s_axi_wdata[13:0]);
        end
    end

    // thermal flag: a new shutdown in the read cycle keeps it set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 1'b0;
        end else if (ot_event) begin
            flag_r <= 1'b1;
        end else if (rd_go && ra_r == tsf_pkg::TEMP_OFS) begin
            flag_r <= 1'b0;
        end
    end

    // discharge drivers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            discharge_on <= '0;
        end else begin
            discharge_on <= (standby || ot_event) ? 12'h000 : cfg_r.discharge;
        end
    end

    // ***************************************************
    // conversion sequencer
    // ***************************************************
    typedef enum logic [0:0] {
        TSF_IDLE,
        TSF_CONV
    } tsf_state_t;
    tsf_state_t st_r;
    logic [3:0] last_r;
    logic [15:0] cnt_r;
    logic done_r;
    logic [11:0] res_r [tsf_pkg::NUM_CELLS];

    assign cmd_stack = wr_go && wa_r == tsf_pkg::CMD_OFS && s_axi_wdata[tsf_pkg::CMD_STACK_BIT];
    assign cmd_cell = wr_go && wa_r == tsf_pkg::CMD_OFS && s_axi_wdata[tsf_pkg::CMD_CELL_BIT];
    assign cmd_idx = s_axi_wdata[tsf_pkg::CMD_IDX_LSB +: 4];
    // an aborted window is not a finished conversion
    assign conv_done_ev = st_r == TSF_CONV && cnt_r == 16'(CONV_CYC - 1) && adc_channel == last_r
                          && cfg_r.adc_en && !ot_event;

    // one cell per window; results stored at the end of each window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= TSF_IDLE;
            adc_channel <= '0;
            last_r <= '0;
            cnt_r <= '0;
            done_r <= 1'b0;
            adc_running <= 1'b0;
            for (int i = 0; i < tsf_pkg::NUM_CELLS; i++)
                res_r[i] <= '0;
        end else begin
            case (st_r)
                TSF_IDLE: begin
                    if (cmd_stack && cfg_r.adc_en && !ot_event) begin
                        st_r <= TSF_CONV;
                        adc_channel <= '0;
                        last_r <= last_cell(cfg_r.ten_cell_select);
                        cnt_r <= '0;
                        done_r <= 1'b0;
                        adc_running <= 1'b1;
                    end else if (cmd_cell && cfg_r.adc_en && !ot_event
                                 && cmd_idx < 4'(tsf_pkg::NUM_CELLS)) begin
                        st_r <= TSF_CONV;
                        adc_channel <= cmd_idx;
                        last_r <= cmd_idx;
                        cnt_r <= '0;
                        done_r <= 1'b0;
                        adc_running <= 1'b1;
                    end
                end
                TSF_CONV: begin
                    if (ot_event || !cfg_r.adc_en) begin
                        st_r <= TSF_IDLE;
                        adc_running <= 1'b0;
                    end else if (cnt_r == 16'(CONV_CYC - 1)) begin
                        cnt_r <= '0;
                        res_r[adc_channel] <= unused_s[adc_channel] ? 12'h000 : adc_data;
                        if (adc_channel == last_r) begin
                            st_r <= TSF_IDLE;
                            done_r <= 1'b1;
                            adc_running <= 1'b0;
                        end else begin
                            adc_channel <= adc_channel + 4'h1;
                        end
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                default: st_r <= TSF_IDLE;
            endcase
        end
    end

    // polling needs the chain above; registers do not
    always_ff @(posedge aclk) begin
        if (!aresetn)
            poll_out <= 1'b0;
        else
            poll_out <= done_r && poll_s;
    end

    // ***************************************************
    // interrupts
    // ***************************************************
    logic [2:0] irq_set;
    // link timeout only when standby is really entered in this cycle
    assign irq_set = {!standby && !link_ev && wd_r == 25'(TIMEOUT_CYC - 1), conv_done_ev, ot_event};

    // sticky status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_go && wa_r == tsf_pkg::IRQ_STAT_OFS)
                irq_stat_r <= (irq_stat_r & ~s_axi_wdata[2:0]) | irq_set;
            else
                irq_stat_r <= irq_stat_r | irq_set;
            if (wr_go && wa_r == tsf_pkg::IRQ_MASK_OFS)
                irq_mask_r <= s_axi_wdata[2:0];
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ***************************************************
    // axi4-lite slave
    // ***************************************************
    function automatic logic mapped(input logic [7:0] a);
        mapped = a[1:0] == 2'h0 && (a <= tsf_pkg::IRQ_MASK_OFS
                 || (a >= tsf_pkg::RES_OFS && a <= tsf_pkg::RES_END_OFS));
    endfunction

    // wr_go and rd_go are the handshake cycles; strobes unused, every write is a full word
    assign wr_go = s_axi_awready && s_axi_wready;
    assign rd_go = s_axi_arready;
    assign wa_r = s_axi_awaddr;
    assign ra_r = s_axi_araddr;

    // write channel: address and data taken together, response one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tsf_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wa_r) ? tsf_pkg::RESP_OKAY : tsf_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= tsf_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(ra_r) ? tsf_pkg::RESP_OKAY : tsf_pkg::RESP_SLVERR;
                s_axi_rdata <= '0;
                case (ra_r)
                    tsf_pkg::CFG_OFS: s_axi_rdata <= {18'h0_0000, cfg_r};
                    tsf_pkg::TEMP_OFS: s_axi_rdata <= {29'h0000_0000, standby, armed, flag_r};
                    tsf_pkg::STAT_OFS: s_axi_rdata <= {24'h00_0000, adc_channel, 2'h0, done_r,
                                                       adc_running};
                    tsf_pkg::IRQ_STAT_OFS: s_axi_rdata <= {29'h0000_0000, irq_stat_r};
                    tsf_pkg::IRQ_MASK_OFS: s_axi_rdata <= {29'h0000_0000, irq_mask_r};
                    default: begin
                        if (mapped(ra_r) && ra_r >= tsf_pkg::RES_OFS)
                            s_axi_rdata <= {20'h0_0000, res_r[4'(ra_r[5:2] - 4'h0)]};
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    sequence ot_rise_s;
        ot_s && !ot_prev_r && armed;
    endsequence
    chk_standby_arming: assert property (@(posedge aclk) disable iff (!aresetn)
        !standby |-> armed) else $error("protection not armed outside standby");
    chk_cmio_arming: assert property (@(posedge aclk) disable iff (!aresetn)
        cmio_s |-> armed) else $error("protection not armed while pins conduct");
    chk_shutdown_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
        ot_rise_s |=> cfg_r == tsf_pkg::CFG_DEFAULT && discharge_on == 12'h000
        && !adc_running) else $error("shutdown left config or adc active");
    chk_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ot_rise_s |=> flag_r) else $error("thermal flag not set");
    chk_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_go && ra_r == tsf_pkg::TEMP_OFS && !ot_event |=> !flag_r)
        else $error("thermal flag not cleared by read");
    chk_stack_len: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r == TSF_IDLE && cmd_stack && cfg_r.adc_en && !ot_event
        |=> last_r == last_cell($past(cfg_r.ten_cell_select)))
        else $error("stack length wrong");
    chk_single_cell: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r == TSF_IDLE && !cmd_stack && cmd_cell && cfg_r.adc_en && !ot_event
        && cmd_idx < 4'hC |=> adc_running && adc_channel == $past(cmd_idx)
        && last_r == $past(cmd_idx))
        else $error("single cell command not taken");
    chk_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r == TSF_CONV && cnt_r == 16'(CONV_CYC - 1) && cfg_r.adc_en && !ot_event
        && unused_s[adc_channel] |=> res_r[$past(adc_channel)] == 12'h000)
        else $error("unused channel not zero");
    chk_standby_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_r == 25'(TIMEOUT_CYC - 1) && !link_ev |=> standby)
        else $error("standby not entered on timeout");
    chk_standby_off: assert property (@(posedge aclk) disable iff (!aresetn)
        standby |=> discharge_on == 12'h000) else $error("discharge on in standby");
    chk_poll_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !poll_s |=> !poll_out) else $error("poll passed through broken chain");
    chk_unarmed_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
        ot_s && !ot_prev_r && !armed && !(wr_go && wa_r == tsf_pkg::CFG_OFS)
        |=> $stable(cfg_r) && (!flag_r || $past(flag_r)))
        else $error("over-temperature acted on while unarmed");
endmodule

// file: tsf_top_tb.sv
// tsf_top_tb: self-checking bench for the thermal shutdown and fault control block
// assumes tsf_pkg and tsf_top compiled first; short timeout and conversion counts
`timescale 1ns/10ps
module tsf_top_tb;
    localparam int TO_CYC = 200;
    localparam int CV_CYC = 8;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, last_resp;
    logic over_temp, cm_io_active, link_activity, poll_from_above, link_en;
    logic [11:0] cell_unused, adc_data, discharge_on;
    logic [3:0] adc_channel;
    logic adc_running, poll_out, standby, irq, irq_a;
    int bad_count = 0;
    int checked = 0;

    // ***************************************************
    // design and partner
    // ***************************************************
    tsf_top #(.TIMEOUT_CYC(TO_CYC), .CONV_CYC(CV_CYC)) tsf_top_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .over_temp(over_temp),
        .cm_io_active(cm_io_active), .link_activity(link_activity),
        .poll_from_above(poll_from_above), .cell_unused(cell_unused),
        .adc_data(adc_data), .discharge_on(discharge_on), .adc_channel(adc_channel),
        .adc_running(adc_running), .poll_out(poll_out), .standby(standby), .irq(irq)
    );
    tsf_afe_model tsf_afe_model_i (
        .aclk(aclk), .adc_channel(adc_channel), .adc_running(adc_running),
        .link_en(link_en), .adc_data(adc_data), .link_activity(link_activity)
    );

    // 10 MHz clock
    initial aclk = 1'b0;
    always #50 aclk = ~aclk;

    // ***************************************************
    // shared tasks
    // ***************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // leading edge keeps two tasks from driving one signal in one time step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        last_resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask

    // polls the done flag; bounded so a stuck sequencer cannot hang the run
    task automatic wait_done();
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 0; i < 300 && v[1] !== 1'b1; i++) axi_rd(tsf_pkg::STAT_OFS, v);
    endtask

    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic sc_reset();
        axi_rd(tsf_pkg::CFG_OFS, rd_v);
        chk(rd_v, 32'h0000_0000);
        axi_rd(tsf_pkg::TEMP_OFS, rd_v);
        chk(rd_v, 32'h0000_0002);
        axi_rd(8'h20, rd_v);
        chk(rd_v, 32'h0000_0000);
        chk(32'(last_resp), 32'(tsf_pkg::RESP_SLVERR));
    endtask

    task automatic sc_stack();
        logic [31:0] e;
        cell_unused <= 12'h008;
        axi_wr(tsf_pkg::CFG_OFS, 32'h0000_3000);
        axi_wr(tsf_pkg::CMD_OFS, 32'h0000_0001);
        wait_done();
        for (int i = 0; i < 12; i++) begin
            e = (i < 10 && i != 3) ? (32'h0000_05A0 | i) : 32'h0000_0000;
            axi_rd(tsf_pkg::RES_OFS + 8'(4 * i), rd_v);
            chk(rd_v, e);
        end
        axi_rd(tsf_pkg::IRQ_STAT_OFS, rd_v);
        chk(rd_v & 32'h0000_0002, 32'h0000_0002);
        // irq follows the mask or status write two edges later
        axi_wr(tsf_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        tick(2);
        irq_a = irq;
        axi_wr(tsf_pkg::IRQ_MASK_OFS, 32'h0000_0007);
        tick(2);
        chk(32'(irq_a ^ irq), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        axi_wr(tsf_pkg::IRQ_STAT_OFS, 32'h0000_0002);
        tick(2);
        chk(32'(irq), 32'h0000_0000);
        chk(32'(poll_out), 32'h0000_0001);
        poll_from_above <= 1'b0;
        tick(6);
        chk(32'(poll_out), 32'h0000_0000);
        poll_from_above <= 1'b1;
    endtask

    task automatic sc_single();
        axi_wr(tsf_pkg::CMD_OFS, 32'h0000_00B2);
        wait_done();
        axi_rd(tsf_pkg::RES_OFS + 8'd44, rd_v);
        chk(rd_v, 32'h0000_05AB);
        axi_rd(tsf_pkg::RES_OFS + 8'd40, rd_v);
        chk(rd_v, 32'h0000_0000);
    endtask

    task automatic sc_shutdown();
        axi_wr(tsf_pkg::CFG_OFS, 32'h0000_2ABC);
        tick(2);
        chk(32'(discharge_on), 32'h0000_0ABC);
        axi_wr(tsf_pkg::CMD_OFS, 32'h0000_0001);
        tick(5);
        over_temp <= 1'b1;
        tick(10);
        chk({20'h0, discharge_on}, 32'h0000_0000);
        chk(32'(adc_running), 32'h0000_0000);
        axi_rd(tsf_pkg::CFG_OFS, rd_v);
        chk(rd_v, 32'h0000_0000);
        axi_rd(tsf_pkg::TEMP_OFS, rd_v);
        chk(rd_v, 32'h0000_0003);
        axi_rd(tsf_pkg::TEMP_OFS, rd_v);
        chk(rd_v, 32'h0000_0002);
        axi_rd(tsf_pkg::IRQ_STAT_OFS, rd_v);
        chk(rd_v & 32'h0000_0001, 32'h0000_0001);
        over_temp <= 1'b0;
    endtask

    task automatic sc_standby();
        axi_wr(tsf_pkg::CFG_OFS, 32'h0000_0FFF);
        link_en <= 1'b0;
        tick(TO_CYC + 60);
        chk(32'(standby), 32'h0000_0001);
        chk({20'h0, discharge_on}, 32'h0000_0000);
        axi_rd(tsf_pkg::TEMP_OFS, rd_v);
        chk(rd_v, 32'h0000_0004);
        axi_rd(tsf_pkg::IRQ_STAT_OFS, rd_v);
        chk(rd_v & 32'h0000_0004, 32'h0000_0004);
        // a rise while unarmed must be ignored
        over_temp <= 1'b1;
        tick(10);
        axi_rd(tsf_pkg::TEMP_OFS, rd_v);
        chk(rd_v, 32'h0000_0004);
        over_temp <= 1'b0;
        tick(6);
        cm_io_active <= 1'b1;
        tick(6);
        axi_rd(tsf_pkg::TEMP_OFS, rd_v);
        chk(rd_v, 32'h0000_0006);
        over_temp <= 1'b1;
        tick(10);
        axi_rd(tsf_pkg::TEMP_OFS, rd_v);
        chk(rd_v, 32'h0000_0007);
        link_en <= 1'b1;
        tick(40);
        chk(32'(standby), 32'h0000_0000);
    endtask

    // ***************************************************
    // run control
    // ***************************************************
    task automatic final_report();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog sized well above the several hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        final_report();
    end

    // reset for 10 cycles, then the scenarios in order
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        {over_temp, cm_io_active} = 2'b00;
        poll_from_above = 1'b1;
        link_en = 1'b1;
        cell_unused = 12'h000;
        tick(10);
        aresetn <= 1'b1;
        sc_reset();
        sc_stack();
        sc_single();
        sc_shutdown();
        sc_standby();
        final_report();
    end
endmodule
